// File: hdl/watchdog_helpers.sv
`default_nettype none
// ---------------------------------------------------------------
// restart window compare
// ---------------------------------------------------------------
module io_window_match
  import watchdog_pkg::*;
(
  input wire io_req_s req_in,        // host i/o cycle
  input wire logic [15:0] base_in,   // window base
  input wire logic [3:0] mask_in,    // low address bits ignored
  input wire logic rd_en_in,         // reads restart
  input wire logic wr_en_in,         // writes restart
  output logic hit_out               // enabled access hit the window
);
  logic [15:0] care;  // address bits that must match
  logic match;        // address inside the window
  assign care = ~{12'h000, mask_in};
  assign match = ((req_in.addr ^ base_in) & care) == 16'h0000;
  assign hit_out = match && ((req_in.rd && rd_en_in) || (req_in.wr && wr_en_in));
endmodule : io_window_match

// ---------------------------------------------------------------
// count step divider
// ---------------------------------------------------------------
module tick_divider
  import watchdog_pkg::*;
(
  input wire logic core_clk_in, // core clock
  input wire logic rst_in,      // sync reset, high
  output logic tick_out         // one-cycle step pulse
);
  localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1);
  logic [15:0] div_r; // cycles since last tick
  // free-running so the step rate never depends on software
  always_ff @(posedge core_clk_in) begin
    if (rst_in || div_r == LAST) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign tick_out = (div_r == LAST);
endmodule : tick_divider
`default_nettype wire

// File: hdl/watchdog_pkg.sv
`default_nettype none
package watchdog_pkg;

  // ---------------------------------------------------------------
  // configuration access ports and indices
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_INDEX_PORT = 16'h0302; // index write port
  localparam logic [15:0] CFG_DATA_PORT = 16'h0303;  // data port for indexed regs
  localparam logic [15:0] POSTCODE_PORT = 16'h0080;  // post code port
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_INT_SELECT = 8'h70;
  localparam logic [7:0] IDX_RESTART_EN = 8'hf1;
  localparam logic [7:0] IDX_W1_BASE_LOW = 8'hf2;
  localparam logic [7:0] IDX_W1_BASE_HIGH = 8'hf3;
  localparam logic [7:0] IDX_W2_BASE_LOW = 8'hf4;
  localparam logic [7:0] IDX_W2_BASE_HIGH = 8'hf5;
  localparam logic [7:0] IDX_WINDOW_MASKS = 8'hf6;

  // ---------------------------------------------------------------
  // runtime register offsets from the i/o base
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_COUNT_LOW = 3'h0;
  localparam logic [2:0] OFS_COUNT_MID = 3'h1;
  localparam logic [2:0] OFS_COUNT_HIGH = 3'h2;
  localparam logic [2:0] OFS_START_LOW = 3'h3;
  localparam logic [2:0] OFS_START_MID = 3'h4;
  localparam logic [2:0] OFS_START_HIGH = 3'h5;
  localparam logic [2:0] OFS_STATUS = 3'h6;
  localparam logic [2:0] OFS_CONTROL = 3'h7;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_SMI_BIT = 1;
  localparam int STAT_SECOND_BIT = 2;
  localparam int CTRL_PERMIT_BIT = 0;
  localparam int CTRL_COUNT_EN_BIT = 1;
  localparam int REN_W1_READ_BIT = 0;
  localparam int REN_W1_WRITE_BIT = 1;
  localparam int REN_W2_READ_BIT = 2;
  localparam int REN_W2_WRITE_BIT = 3;
  localparam int REN_POSTCODE_BIT = 4;

  // ---------------------------------------------------------------
  // values after reset and interrupt codes
  // ---------------------------------------------------------------
  localparam logic [23:0] START_COUNT_RST = 24'h004000;
  localparam logic [7:0] CONTROL_RST = 8'h03;
  localparam logic [7:0] WINDOW_MASKS_RST = 8'hff;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] INT_SEL_OFF = 4'h0;
  localparam logic [3:0] INT_SEL_SMI = 4'h2;

  // ---------------------------------------------------------------
  // timing: one count step per tick
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : TICK_PERIOD_NS / CLK_PERIOD_NS;

  // one host i/o cycle, held for a single clock
  typedef struct packed {
    logic [15:0] addr; // i/o address
    logic wr;          // write strobe
    logic rd;          // read strobe
    logic [7:0] wdata; // write data
  } io_req_s;

endpackage : watchdog_pkg
`default_nettype wire

// File: hdl/watchdog_unit.sv
// Operation
// RL1 - window one base at f2h/f3h
// RL2 - window two base at f4h/f5h
// RL3 - mask register f6h, window one high
// RL4 - running count bytes at offsets 0-2
// RL5 - starting count bytes at offsets 3-5
// RL6 - timeout flag set at count zero
// RL7 - timeout flag raises selected interrupt
// RL8 - timeout flag cleared by enabled events
// RL9 - second timeout flag, write one clears
// RL10 - smi flag set only when smi selected
// RL11 - control: bit1 counts, bit0 permits reset
// RL12 - restart enables at index f1h
// RL13 - interrupt select routes timeout
// RL14 - reset values of start, status, control
// RL15 - activate bit switches watchdog on
// RL16 - reload count on restart and timeout
// RL17 - second timeout drives board reset
`default_nettype none
module watchdog_unit
  import watchdog_pkg::*;
(
  input wire logic core_clk_in,        // 125 mhz core clock
  input wire logic rst_in,             // sync reset, high
  input wire io_req_s io_req_in,       // host i/o cycle
  output logic [7:0] io_rdata_out,     // read data
  output logic io_rdata_valid_out,     // read data valid pulse
  output logic [15:0] irq_out,         // legacy interrupt lines
  output logic smi_out,                // smi request
  output logic board_reset_out         // board reset request
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] cfg_index_r;     // selected config index
  logic active_r;              // watchdog switched on
  logic [15:0] io_base_r;      // runtime register base
  logic [3:0] int_sel_r;       // interrupt routing code
  logic [4:0] restart_en_r;    // restart event enables
  logic [15:0] w1_base_r;      // first_window_base
  logic [15:0] w2_base_r;      // second_window_base
  logic [7:0] masks_r;         // first/second_window_mask
  logic [23:0] count_r;        // running count
  logic [23:0] start_r;        // starting count
  logic timeout_flag_r;        // timeout_flag
  logic smi_timeout_flag_r;    // smi_timeout_flag
  logic second_timeout_flag_r; // second_timeout_flag
  logic count_enable_r;        // count_enable
  logic board_reset_permit_r;  // board_reset_permit

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // runtime register hit at one offset
  function automatic logic rt_hit(input logic [15:0] addr, input logic [15:0] base,
                                  input logic act, input logic [2:0] ofs);
    rt_hit = act && (addr[15:3] == base[15:3]) && (addr[2:0] == ofs);
  endfunction : rt_hit

  // replace one byte of a 24-bit value
  function automatic logic [23:0] put_byte(input logic [23:0] val, input logic [1:0] sel,
                                           input logic [7:0] data);
    logic [23:0] res;
    res = val;
    case (sel)
      2'h0: res[7:0] = data;
      2'h1: res[15:8] = data;
      default: res[23:16] = data;
    endcase
    put_byte = res;
  endfunction : put_byte

  logic tick;          // count step enable
  logic cfg_data_wr;   // write to indexed config reg
  logic w1_hit;        // first window restart access
  logic w2_hit;        // second window restart access
  logic post_hit;      // post code restart write
  logic restart_evt;   // any enabled restart
  logic timeout_evt;   // count reaches zero
  logic status_wr;     // status register write
  logic count_wr;      // running count byte write
  logic [1:0] count_sel; // which count byte
  logic [15:0] irq_nxt;  // routed interrupt lines

  assign cfg_data_wr = io_req_in.wr && (io_req_in.addr == CFG_DATA_PORT);
  assign status_wr = io_req_in.wr && rt_hit(io_req_in.addr, io_base_r, active_r, OFS_STATUS);
  assign count_wr = io_req_in.wr && active_r && (io_req_in.addr[15:3] == io_base_r[15:3])
                    && (io_req_in.addr[2:0] <= OFS_COUNT_HIGH); // RL4
  assign count_sel = io_req_in.addr[1:0];

  tick_divider u_tick (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );

  // ---------------------------------------------------------------
  // restart sources
  // ---------------------------------------------------------------
  io_window_match u_w1 (
    .req_in(io_req_in),
    .base_in(w1_base_r),
    .mask_in(masks_r[7:4]),
    .rd_en_in(restart_en_r[REN_W1_READ_BIT]),
    .wr_en_in(restart_en_r[REN_W1_WRITE_BIT]),
    .hit_out(w1_hit)
  );
  io_window_match u_w2 (
    .req_in(io_req_in),
    .base_in(w2_base_r),
    .mask_in(masks_r[3:0]),
    .rd_en_in(restart_en_r[REN_W2_READ_BIT]),
    .wr_en_in(restart_en_r[REN_W2_WRITE_BIT]),
    .hit_out(w2_hit)
  );
  // RL12: each source counts only while its enable is set
  assign post_hit = io_req_in.wr && (io_req_in.addr == POSTCODE_PORT)
                    && restart_en_r[REN_POSTCODE_BIT]; // RL12
  assign restart_evt = active_r && (w1_hit || w2_hit || post_hit); // RL12 RL15
  // zero is reached on the step that leaves one; a zero start also times out
  assign timeout_evt = active_r && count_enable_r && tick && (count_r <= 24'h000001); // RL6 RL11

  // ---------------------------------------------------------------
  // config index and indexed registers
  // ---------------------------------------------------------------
  // index port is always open so software can reach activate
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cfg_index_r <= BYTE_RST;
    end else if (io_req_in.wr && io_req_in.addr == CFG_INDEX_PORT) begin
      cfg_index_r <= io_req_in.wdata;
    end
  end

  // indexed configuration writes
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      active_r <= 1'b0;
      io_base_r <= 16'h0000;
      int_sel_r <= INT_SEL_OFF;
      restart_en_r <= 5'h00;
      w1_base_r <= 16'h0000;
      w2_base_r <= 16'h0000;
      masks_r <= WINDOW_MASKS_RST;
    end else if (cfg_data_wr) begin
      case (cfg_index_r)
        IDX_ACTIVATE: active_r <= io_req_in.wdata[0]; // RL15
        IDX_BASE_HIGH: io_base_r[15:8] <= io_req_in.wdata;
        // low three base bits stay zero: eight registers per base
        IDX_BASE_LOW: io_base_r[7:0] <= {io_req_in.wdata[7:3], 3'h0};
        IDX_INT_SELECT: int_sel_r <= io_req_in.wdata[3:0]; // RL13
        IDX_RESTART_EN: restart_en_r <= io_req_in.wdata[4:0]; // RL12
        IDX_W1_BASE_LOW: w1_base_r[7:0] <= io_req_in.wdata; // RL1
        IDX_W1_BASE_HIGH: w1_base_r[15:8] <= io_req_in.wdata; // RL1
        IDX_W2_BASE_LOW: w2_base_r[7:0] <= io_req_in.wdata; // RL2
        IDX_W2_BASE_HIGH: w2_base_r[15:8] <= io_req_in.wdata; // RL2
        IDX_WINDOW_MASKS: masks_r <= io_req_in.wdata; // RL3
        default: ; // unknown index: write dropped
      endcase
    end
  end

  // ---------------------------------------------------------------
  // starting count and control
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      start_r <= START_COUNT_RST; // RL14
      count_enable_r <= CONTROL_RST[CTRL_COUNT_EN_BIT]; // RL14
      board_reset_permit_r <= CONTROL_RST[CTRL_PERMIT_BIT]; // RL14
    end else if (io_req_in.wr && active_r && io_req_in.addr[15:3] == io_base_r[15:3]) begin
      case (io_req_in.addr[2:0])
        OFS_START_LOW: start_r <= put_byte(start_r, 2'h0, io_req_in.wdata); // RL5
        OFS_START_MID: start_r <= put_byte(start_r, 2'h1, io_req_in.wdata); // RL5
        OFS_START_HIGH: start_r <= put_byte(start_r, 2'h2, io_req_in.wdata); // RL5
        OFS_CONTROL: begin
          count_enable_r <= io_req_in.wdata[CTRL_COUNT_EN_BIT]; // RL11
          board_reset_permit_r <= io_req_in.wdata[CTRL_PERMIT_BIT]; // RL11
        end
        default: ; // count and status handled elsewhere
      endcase
    end
  end

  // ---------------------------------------------------------------
  // running count
  // ---------------------------------------------------------------
  // a software byte write beats a reload, which beats a step
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count_r <= START_COUNT_RST;
    end else if (count_wr) begin
      count_r <= put_byte(count_r, count_sel, io_req_in.wdata); // RL4
    end else if (restart_evt || timeout_evt) begin
      count_r <= start_r; // RL16
    end else if (active_r && count_enable_r && tick) begin
      count_r <= count_r - 24'h000001; // RL11
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // a timeout in the clearing cycle wins, so no timeout is lost
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      timeout_flag_r <= 1'b0; // RL14
    end else if (timeout_evt) begin
      timeout_flag_r <= 1'b1; // RL6
    end else if (restart_evt || (status_wr && io_req_in.wdata[STAT_TIMEOUT_BIT])) begin
      timeout_flag_r <= 1'b0; // RL8
    end
  end

  // smi flag follows the timeout flag's life but only under smi routing
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      smi_timeout_flag_r <= 1'b0;
    end else if (timeout_evt && int_sel_r == INT_SEL_SMI) begin
      smi_timeout_flag_r <= 1'b1; // RL10
    end else if (restart_evt || (status_wr && io_req_in.wdata[STAT_TIMEOUT_BIT])) begin
      smi_timeout_flag_r <= 1'b0;
    end
  end

  // second timeout needs the first still pending and reset permitted
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      second_timeout_flag_r <= 1'b0;
    end else if (timeout_evt && timeout_flag_r && board_reset_permit_r) begin
      second_timeout_flag_r <= 1'b1; // RL9
    end else if (status_wr && io_req_in.wdata[STAT_SECOND_BIT]) begin
      second_timeout_flag_r <= 1'b0; // RL9
    end
  end

  // ---------------------------------------------------------------
  // interrupt routing and board reset
  // ---------------------------------------------------------------
  // codes 0, 8, 13, 14 and 15 leave every line quiet; 2 is smi
  always_comb begin
    irq_nxt = 16'h0000;
    case (int_sel_r)
      4'h0, 4'h2, 4'h8, 4'hd, 4'he, 4'hf: irq_nxt = 16'h0000; // RL13
      default: irq_nxt[int_sel_r] = timeout_flag_r && active_r; // RL7 RL13
    endcase
  end

  // level outputs, registered to keep them glitch free
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_out <= 16'h0000;
      smi_out <= 1'b0;
      board_reset_out <= 1'b0;
    end else begin
      irq_out <= irq_nxt; // RL7
      smi_out <= active_r && smi_timeout_flag_r; // RL7 RL13
      board_reset_out <= second_timeout_flag_r && board_reset_permit_r; // RL17
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // enabled window reads restart the count, other reads have no side effects; data one cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      io_rdata_out <= BYTE_RST;
      io_rdata_valid_out <= 1'b0;
    end else begin
      io_rdata_valid_out <= io_req_in.rd;
      if (io_req_in.rd && io_req_in.addr == CFG_INDEX_PORT) begin
        io_rdata_out <= cfg_index_r;
      end else if (io_req_in.rd && io_req_in.addr == CFG_DATA_PORT) begin
        case (cfg_index_r)
          IDX_ACTIVATE: io_rdata_out <= {7'h00, active_r};
          IDX_BASE_HIGH: io_rdata_out <= io_base_r[15:8];
          IDX_BASE_LOW: io_rdata_out <= io_base_r[7:0];
          IDX_INT_SELECT: io_rdata_out <= {4'h0, int_sel_r};
          IDX_RESTART_EN: io_rdata_out <= {3'h0, restart_en_r};
          IDX_W1_BASE_LOW: io_rdata_out <= w1_base_r[7:0]; // RL1
          IDX_W1_BASE_HIGH: io_rdata_out <= w1_base_r[15:8]; // RL1
          IDX_W2_BASE_LOW: io_rdata_out <= w2_base_r[7:0]; // RL2
          IDX_W2_BASE_HIGH: io_rdata_out <= w2_base_r[15:8]; // RL2
          IDX_WINDOW_MASKS: io_rdata_out <= masks_r; // RL3
          default: io_rdata_out <= BYTE_RST;
        endcase
      end else if (io_req_in.rd && active_r && io_req_in.addr[15:3] == io_base_r[15:3]) begin
        case (io_req_in.addr[2:0])
          OFS_COUNT_LOW: io_rdata_out <= count_r[7:0]; // RL4
          OFS_COUNT_MID: io_rdata_out <= count_r[15:8]; // RL4
          OFS_COUNT_HIGH: io_rdata_out <= count_r[23:16]; // RL4
          OFS_START_LOW: io_rdata_out <= start_r[7:0]; // RL5
          OFS_START_MID: io_rdata_out <= start_r[15:8]; // RL5
          OFS_START_HIGH: io_rdata_out <= start_r[23:16]; // RL5
          OFS_STATUS: io_rdata_out <= {5'h00, second_timeout_flag_r, smi_timeout_flag_r, timeout_flag_r};
          default: io_rdata_out <= {6'h00, count_enable_r, board_reset_permit_r};
        endcase
      end else if (io_req_in.rd) begin
        io_rdata_out <= BYTE_RST; // unmapped read gives zero
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  timeout_sets_flag_a: assert property (timeout_evt |=> timeout_flag_r && count_r == $past(start_r) // RL6
    || $past(count_wr)) else $error("timeout did not set flag or reload");
  irq_line_route_a: assert property ($rose(timeout_flag_r) && int_sel_r == 4'h5 && active_r // RL7
    |=> irq_out == 16'h0020) else $error("irq line 5 not raised");
  enabled_clear_a: assert property (restart_evt && !timeout_evt |=> !timeout_flag_r) // RL8
    else $error("restart did not clear timeout flag");
  second_flag_set_a: assert property (timeout_evt && timeout_flag_r && board_reset_permit_r // RL9
    |=> second_timeout_flag_r ##1 board_reset_out || !board_reset_permit_r)
    else $error("second timeout or board reset missing");
  smi_only_select_a: assert property ($rose(smi_timeout_flag_r) |-> $past(int_sel_r) == INT_SEL_SMI) // RL10
    else $error("smi flag set without smi routing");
  count_hold_a: assert property (active_r && !count_enable_r && !count_wr && !restart_evt // RL11
    |=> count_r == $past(count_r)) else $error("count moved while disabled");
  disabled_lines_a: assert property (int_sel_r == INT_SEL_OFF [*2] |-> irq_out == 16'h0000) // RL13
    else $error("interrupt line active while routing off");
  // timeout_evt needs active_r in the same cycle, so a clear flag must stay clear
  inactive_quiet_a: assert property (!active_r && !timeout_flag_r |=> !timeout_flag_r) // RL15
    else $error("timeout while switched off");
  restart_reload_a: assert property (restart_evt && !count_wr |=> count_r == $past(start_r)) // RL16
    else $error("restart did not reload count");
  reset_values_a: assert property ($fell(rst_in) |-> start_r == START_COUNT_RST // RL14
    && !timeout_flag_r && count_enable_r && board_reset_permit_r) else $error("bad reset values");

  timeout_seen_c: cover property (timeout_evt);
  second_seen_c: cover property (timeout_evt && timeout_flag_r && board_reset_permit_r);
  window_restart_c: cover property (active_r && (w1_hit || w2_hit));
  board_reset_c: cover property ($rose(board_reset_out));

endmodule : watchdog_unit
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import watchdog_pkg::*;
  // ---------------------------------------------------------------
  // bench signals
  // ---------------------------------------------------------------
  logic clk; // 125 mhz core clock
  logic rst_in; // sync reset, high
  io_req_s req; // host i/o cycle
  logic [7:0] rdata; // read data
  logic rvalid; // read valid pulse
  logic [15:0] irq; // legacy lines
  logic smi; // smi request
  logic brst; // board reset request
  int n_fail = 0; // mismatches
  int total_checks = 0; // comparisons made
  int cycles = 0; // hang guard
  localparam logic [15:0] BASE = 16'h0310; // runtime base used throughout

  watchdog_unit u_watchdog_unit (.core_clk_in(clk), .rst_in(rst_in), .io_req_in(req), .io_rdata_out(rdata),
    .io_rdata_valid_out(rvalid), .irq_out(irq), .smi_out(smi), .board_reset_out(brst));

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // tests need about 4100 cycles; margin for slow steps
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one-cycle strobe, launched off the falling edge
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    req = '0;
  endtask : io_wr
  // answer lands one edge after the strobe, so look at the next low phase
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    check("rdata_valid", {23'h0, rvalid}, 24'h1);
    check(what, {16'h0, rdata}, {16'h0, exp});
  endtask : rd_chk
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    io_wr(CFG_INDEX_PORT, idx);
    io_wr(CFG_DATA_PORT, d);
  endtask : cfg_wr
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values;
    cfg_wr(IDX_BASE_HIGH, BASE[15:8]);
    cfg_wr(IDX_BASE_LOW, BASE[7:0]);
    rd_chk(BASE + 16'h7, 8'h00, "control while off");
    cfg_wr(IDX_ACTIVATE, 8'h01);
    rd_chk(BASE + 16'h3, 8'h00, "start low");
    rd_chk(BASE + 16'h4, 8'h40, "start mid");
    rd_chk(BASE + 16'h5, 8'h00, "start high");
    rd_chk(BASE + 16'h6, 8'h00, "status");
    rd_chk(BASE + 16'h7, 8'h03, "control");
  endtask : t_reset_values
  task automatic t_config_regs;
    for (int i = 0; i < 5; i++) begin
      cfg_wr(IDX_W1_BASE_LOW + 8'(i), 8'ha5 ^ 8'(i * 17));
      io_wr(CFG_INDEX_PORT, IDX_W1_BASE_LOW + 8'(i));
      rd_chk(CFG_DATA_PORT, 8'ha5 ^ 8'(i * 17), "window cfg");
    end
  endtask : t_config_regs
  // count 4 times out within 500 cycles; the next one needs 500 more
  task automatic arm_count(input logic [7:0] ctrl);
    io_wr(BASE + 16'h7, 8'h00);
    io_wr(BASE + 16'h3, 8'h04);
    io_wr(BASE + 16'h4, 8'h00);
    io_wr(BASE + 16'h0, 8'h04);
    io_wr(BASE + 16'h1, 8'h00);
    io_wr(BASE + 16'h2, 8'h00);
    io_wr(BASE + 16'h6, 8'h07);
    io_wr(BASE + 16'h7, ctrl);
    repeat (600) @(negedge clk);
  endtask : arm_count
  task automatic t_timeout_irq;
    cfg_wr(IDX_INT_SELECT, 8'h05);
    arm_count(8'h02);
    rd_chk(BASE + 16'h6, 8'h01, "status after timeout");
    check("irq line", {8'h0, irq}, 24'h000020);
    io_wr(BASE + 16'h6, 8'h01);
    rd_chk(BASE + 16'h6, 8'h00, "status after clear");
    check("irq cleared", {8'h0, irq}, 24'h0);
    io_wr(BASE + 16'h7, 8'h00);
    io_wr(BASE + 16'h0, 8'h09);
    rd_chk(BASE + 16'h5, 8'h00, "start high kept");
    repeat (300) @(negedge clk);
    rd_chk(BASE + 16'h0, 8'h09, "count held");
  endtask : t_timeout_irq
  task automatic t_smi_second;
    cfg_wr(IDX_INT_SELECT, 8'h02);
    arm_count(8'h03);
    rd_chk(BASE + 16'h6, 8'h03, "status smi");
    check("smi", {23'h0, smi}, 24'h1);
    check("no board reset", {23'h0, brst}, 24'h0);
    repeat (500) @(negedge clk);
    rd_chk(BASE + 16'h6, 8'h07, "second timeout");
    check("board reset", {23'h0, brst}, 24'h1);
    io_wr(BASE + 16'h6, 8'h04);
    rd_chk(BASE + 16'h6, 8'h03, "second cleared");
  endtask : t_smi_second
  // a timeout, then a restart event while counting is paused
  task automatic restart_by(input logic [15:0] miss, input logic [15:0] hit);
    arm_count(8'h02);
    io_wr(BASE + 16'h7, 8'h00);
    io_wr(BASE + 16'h0, 8'h09);
    io_wr(miss, 8'h55);
    rd_chk(BASE + 16'h6, 8'h01, "flag after miss");
    io_wr(hit, 8'h55);
    rd_chk(BASE + 16'h6, 8'h00, "flag after restart");
    rd_chk(BASE + 16'h0, 8'h04, "count reloaded");
  endtask : restart_by
  task automatic t_restart;
    cfg_wr(IDX_INT_SELECT, 8'h05);
    cfg_wr(IDX_RESTART_EN, 8'h12);
    cfg_wr(IDX_W1_BASE_LOW, 8'h00);
    cfg_wr(IDX_W1_BASE_HIGH, 8'h04);
    cfg_wr(IDX_WINDOW_MASKS, 8'h30);
    restart_by(16'h0404, 16'h0403);
    restart_by(16'h0081, POSTCODE_PORT);
  endtask : t_restart
  // window two restarts on reads only; code 8 keeps every line quiet
  task automatic t_window_two;
    cfg_wr(IDX_INT_SELECT, 8'h08);
    cfg_wr(IDX_RESTART_EN, 8'h04);
    cfg_wr(IDX_W2_BASE_LOW, 8'h20);
    cfg_wr(IDX_W2_BASE_HIGH, 8'h05);
    cfg_wr(IDX_WINDOW_MASKS, 8'h03);
    arm_count(8'h02);
    check("irq code 8 off", {8'h0, irq}, 24'h0);
    io_wr(BASE + 16'h7, 8'h00);
    io_wr(16'h0523, 8'h55);
    rd_chk(BASE + 16'h6, 8'h01, "flag after window write");
    rd_chk(16'h0522, 8'h00, "window read data");
    rd_chk(BASE + 16'h6, 8'h00, "flag after window read");
    rd_chk(BASE + 16'h0, 8'h04, "count reloaded by read");
  endtask : t_window_two

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    req = '0;
    repeat (16) @(negedge clk);
    rst_in = 1'b0;
    t_reset_values();
    t_config_regs();
    t_timeout_irq();
    t_smi_second();
    t_restart();
    t_window_two();
    results();
  end
endmodule : tb_top
`default_nettype wire
